// ---- logic/sea_ctrl.sv ----
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - The control word is decoded at byte offset a0h of the register space.
// - Writing one to start bit 0 launches one access with current settings for commands 001 to 110.
// - Command bits 3:1: 001 write status, 010 write data, 011 read data.
// - Command 100 write disable, 101 read status, 110 write enable.
// - Bit 4 reads one only after a successful autoload after fundamental reset.
// - Bit 5 set suppresses autoload; resets to one.
// - Bits 7:6 pick serial clock: 01 divide by 64, 11 test mode.
// - Bit 8 mirrors the memory's write-in-process flag; resets to zero.
// - Bit 9 mirrors the memory's write enable latch; resets to zero.
// - Bits 10 and 11 hold the two block protection flags, writable.
// - Bit 15 holds status write protect enable; bits 14:12 are read only.
// - Bits 15:0 at a4h hold the memory address for the access.
// - Bits 31:16 at a4h hold write data or returned read data.
module sea_ctrl
	import sea_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Serial memory pins and fundamental reset pin
	output logic eeprom_sck,
	output logic eeprom_cs_n,
	output logic eeprom_mosi,
	input wire logic eeprom_miso,
	input wire logic fundamental_reset_input_n,
	// Interrupt
	output logic irq
);

	typedef enum {C_IDLE, C_RUN, C_ALOAD} sea_cst_t;

	function automatic sea_sel_t decode(input logic [AXI_AW-1:0] a);
		if (a[AXI_AW-1:2] == OFF_CTRL[AXI_AW-1:2])
			return SEL_CTRL;
		else if (a[AXI_AW-1:2] == OFF_ADDR_DATA[AXI_AW-1:2])
			return SEL_AD;
		else if (a[AXI_AW-1:2] == OFF_IRQ_STAT[AXI_AW-1:2])
			return SEL_IST;
		else if (a[AXI_AW-1:2] == OFF_IRQ_MASK[AXI_AW-1:2])
			return SEL_IMSK;
		else
			return SEL_NONE;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	// The low opcode bits equal the command code, so the opcode is built from it.
	function automatic sea_req_t build_req(input logic [2:0] cmd, input logic [31:0] ad,
		input logic [7:0] stat);
		sea_req_t q;
		q.opcode = {5'h00, cmd};
		q.has_addr = (cmd == CMD_WRITE) || (cmd == CMD_READ);
		q.nbytes = q.has_addr ? 2'd2 : ((cmd == CMD_WRSR || cmd == CMD_RDSR) ? 2'd1 : 2'd0);
		q.addr = ad[15:0];
		q.wdata = (cmd == CMD_WRSR) ? {8'h00, stat} : ad[31:16];
		return q;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and the serial clock divider.
	logic [15:0] ctrl_r, ctrl_nxt;
	logic fr_s1_r, fr_s2_r, fr_d_r, miso_s1_r, miso_s2_r;
	logic [5:0] div_r, div_nxt, half;
	logic tick;

	assign half = (ctrl_r[CTRL_RATE_LO +: 2] == RATE_TEST) ? HALF_TEST : HALF_NORM;
	assign tick = (div_r >= half - 6'd1);
	assign div_nxt = tick ? 6'd0 : div_r + 6'd1;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fr_s1_r <= 1'b0;
			fr_s2_r <= 1'b0;
			fr_d_r <= 1'b0;
			miso_s1_r <= 1'b0;
			miso_s2_r <= 1'b0;
			div_r <= '0;
		end else begin
			fr_s1_r <= fundamental_reset_input_n;
			fr_s2_r <= fr_s1_r;
			fr_d_r <= fr_s2_r;
			miso_s1_r <= eeprom_miso;
			miso_s2_r <= miso_s1_r;
			div_r <= div_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register bus slave.
	logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [AXI_AW-1:0] aw_addr_r, aw_addr_nxt;
	logic [31:0] w_data_r, w_data_nxt, rdata_r, rdata_nxt, rd_word;
	logic [3:0] w_strb_r, w_strb_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic do_wr;
	sea_sel_t wsel, rsel;

	logic [31:0] ad_r, ad_nxt, ctrl_wr, ad_wr, msk_wr;
	logic [IRQ_W-1:0] istat_r, istat_nxt, imask_r, imask_nxt, ev, clr;
	logic al_ok_r, al_ok_nxt, al_pend_r, al_pend_nxt, sw_free;
	sea_cst_t st_r, st_nxt;

	assign s_axi_awready = !aw_ok_r && !bvalid_r;
	assign s_axi_wready = !w_ok_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign do_wr = aw_ok_r && w_ok_r && !bvalid_r;
	assign wsel = decode(aw_addr_r);
	assign rsel = decode(s_axi_araddr);

	always_comb begin
		if (rsel == SEL_CTRL)
			rd_word = {16'h0000, ctrl_r[15:CTRL_AL_DIS], al_ok_r, ctrl_r[CTRL_AL_STAT-1:0]};
		else if (rsel == SEL_AD)
			rd_word = ad_r;
		else if (rsel == SEL_IST)
			rd_word = {29'h0, istat_r};
		else if (rsel == SEL_IMSK)
			rd_word = {29'h0, imask_r};
		else
			rd_word = 32'h0000_0000;
	end

	always_comb begin
		aw_ok_nxt = aw_ok_r;
		aw_addr_nxt = aw_addr_r;
		w_ok_nxt = w_ok_r;
		w_data_nxt = w_data_r;
		w_strb_nxt = w_strb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_ok_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_ok_nxt = 1'b1;
			w_data_nxt = s_axi_wdata;
			w_strb_nxt = s_axi_wstrb;
		end
		if (do_wr) begin
			aw_ok_nxt = 1'b0;
			w_ok_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rdata_nxt = rd_word;
			rresp_nxt = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok_r <= 1'b0;
			aw_addr_r <= '0;
			w_ok_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else begin
			aw_ok_r <= aw_ok_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_ok_r <= w_ok_nxt;
			w_data_r <= w_data_nxt;
			w_strb_r <= w_strb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	////////////////////////////////////////////////////////////////////////////
	// Access sequencer and register file.
	logic eng_start, eng_busy, eng_done;
	logic [15:0] eng_rdata;
	sea_req_t eng_req;
	sea_pins_t pins;

	// Settings are frozen from start until completion so a frame never mixes two.
	assign sw_free = (st_r == C_IDLE) && !ctrl_r[CTRL_START] && !al_pend_r;
	assign ctrl_wr = merge({16'h0000, ctrl_r}, w_data_r, w_strb_r);
	assign ad_wr = merge(ad_r, w_data_r, w_strb_r);
	assign msk_wr = merge({29'h0, imask_r}, w_data_r, w_strb_r);
	assign clr = (do_wr && wsel == SEL_IST && w_strb_r[0]) ? w_data_r[IRQ_W-1:0] : '0;
	assign eng_req = al_pend_r ? build_req(CMD_READ, {16'h0000, AUTOLOAD_ADDR}, 8'h00)
		: build_req(ctrl_r[CTRL_CMD_LO +: 3], ad_r, ctrl_r[15:8]);

	always_comb begin
		st_nxt = st_r;
		ctrl_nxt = ctrl_r;
		ad_nxt = ad_r;
		al_ok_nxt = al_ok_r;
		al_pend_nxt = al_pend_r;
		imask_nxt = imask_r;
		ev = '0;
		eng_start = 1'b0;
		if (do_wr && wsel == SEL_CTRL && sw_free)
			ctrl_nxt = (ctrl_r & ~CTRL_SW_MASK) | (ctrl_wr[15:0] & CTRL_SW_MASK);
		if (do_wr && wsel == SEL_AD && sw_free)
			ad_nxt = ad_wr;
		if (do_wr && wsel == SEL_IMSK)
			imask_nxt = msk_wr[IRQ_W-1:0];
		case (st_r)
			C_IDLE: if (al_pend_r) begin
				eng_start = 1'b1;
				al_pend_nxt = 1'b0;
				st_nxt = C_ALOAD;
			end else if (ctrl_r[CTRL_START]) begin
				// Codes 000 and 111 do nothing: start drops with no frame sent.
				if (ctrl_r[3:1] != 3'h0 && ctrl_r[3:1] != 3'h7) begin
					eng_start = 1'b1;
					st_nxt = C_RUN;
				end else begin
					ctrl_nxt[CTRL_START] = 1'b0;
				end
			end
			C_RUN: if (eng_done) begin
				ctrl_nxt[CTRL_START] = 1'b0;
				ev[IRQ_DONE] = 1'b1;
				st_nxt = C_IDLE;
				if (ctrl_r[3:1] == CMD_READ)
					ad_nxt[31:16] = eng_rdata;
				if (ctrl_r[3:1] == CMD_RDSR)
					ctrl_nxt[15:CTRL_STAT_LO] = eng_rdata[7:0];
			end
			C_ALOAD: if (eng_done) begin
				st_nxt = C_IDLE;
				if (eng_rdata == AUTOLOAD_SIG) begin
					al_ok_nxt = 1'b1;
					ev[IRQ_AL_OK] = 1'b1;
				end else begin
					ev[IRQ_AL_FAIL] = 1'b1;
				end
			end
			default: st_nxt = C_IDLE;
		endcase
		if (fr_s2_r && !fr_d_r && !ctrl_r[CTRL_AL_DIS])
			al_pend_nxt = 1'b1;
		if (!fr_s2_r) begin
			al_ok_nxt = 1'b0;
			al_pend_nxt = 1'b0;
		end
		istat_nxt = (istat_r & ~clr) | ev;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= C_IDLE;
			ctrl_r <= CTRL_RST;
			ad_r <= ADDR_DATA_RST;
			al_ok_r <= 1'b0;
			al_pend_r <= 1'b0;
			istat_r <= IRQ_RST;
			imask_r <= IRQ_RST;
		end else begin
			st_r <= st_nxt;
			ctrl_r <= ctrl_nxt;
			ad_r <= ad_nxt;
			al_ok_r <= al_ok_nxt;
			al_pend_r <= al_pend_nxt;
			istat_r <= istat_nxt;
			imask_r <= imask_nxt;
		end
	end

	assign irq = |(istat_r & imask_r);

	sea_spi_eng u_eng (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(eng_start),
		.req(eng_req),
		.tick(tick),
		.busy(eng_busy),
		.done(eng_done),
		.rdata(eng_rdata),
		.pins(pins),
		.miso_s(miso_s2_r)
	);

	assign eeprom_sck = pins.sck;
	assign eeprom_cs_n = pins.cs_n;
	assign eeprom_mosi = pins.mosi;

	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	start_launch_a: assert property (st_r == C_IDLE && !al_pend_r && ctrl_r[0]
		&& ctrl_r[3:1] inside {[3'h1:3'h6]} |=> st_r == C_RUN && eng_busy)
		else $error("start did not launch an access");
	opcode_map_a: assert property (eng_start && !al_pend_r
		|-> eng_req.opcode == {5'h00, ctrl_r[3:1]}) else $error("wrong opcode");
	addr_req_a: assert property (eng_start && !al_pend_r && ctrl_r[3:1] == CMD_READ
		|-> eng_req.addr == ad_r[15:0] && eng_req.nbytes == 2'd2)
		else $error("read frame lacks address");
	al_stat_a: assert property ($rose(al_ok_r) |-> $past(st_r == C_ALOAD && eng_done
		&& eng_rdata == AUTOLOAD_SIG)) else $error("autoload status without match");
	al_dis_a: assert property ($rose(al_pend_r) |-> $past(!ctrl_r[CTRL_AL_DIS]))
		else $error("autoload while disabled");
	// Outside test mode a tick may only close a full half period, even after a rate change.
	rate_norm_a: assert property (tick && ctrl_r[7:6] != RATE_TEST
		|-> div_r == HALF_NORM - 6'd1) else $error("serial clock too fast");
	rdsr_upd_a: assert property (st_r == C_RUN && eng_done && ctrl_r[3:1] == CMD_RDSR
		|=> ctrl_r[15:8] == $past(eng_rdata[7:0])) else $error("status not mirrored");
	read_upd_a: assert property (st_r == C_RUN && eng_done && ctrl_r[3:1] == CMD_READ
		|=> ad_r[31:16] == $past(eng_rdata) && !ctrl_r[0]) else $error("read not returned");
	ro_bits_a: assert property (!(st_r == C_RUN && eng_done)
		|=> $stable(ctrl_r[14:8] & 7'h73)) else $error("read only status changed");
	set_wins_a: assert property (ev[IRQ_DONE] |=> istat_r[IRQ_DONE])
		else $error("event lost to clear");
	bhold_a: assert property (bvalid_r && !s_axi_bready |=> bvalid_r && $stable(bresp_r))
		else $error("write response dropped");

	read_cov: cover property (st_r == C_RUN && eng_done && ctrl_r[3:1] == CMD_READ);
	write_cov: cover property (st_r == C_RUN && eng_done && ctrl_r[3:1] == CMD_WRITE);
	al_cov: cover property ($rose(al_ok_r));
	irq_cov: cover property ($rose(irq));

endmodule // sea_ctrl

// ---- logic/sea_pkg.sv ----
package sea_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses on the register bus.
	localparam int AXI_AW = 12;
	localparam logic [AXI_AW-1:0] OFF_CTRL = 12'h0a0;
	localparam logic [AXI_AW-1:0] OFF_ADDR_DATA = 12'h0a4;
	localparam logic [AXI_AW-1:0] OFF_IRQ_STAT = 12'h100;
	localparam logic [AXI_AW-1:0] OFF_IRQ_MASK = 12'h104;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// Control word fields.
	localparam int CTRL_START = 0;
	localparam int CTRL_CMD_LO = 1;
	localparam int CTRL_AL_STAT = 4;
	localparam int CTRL_AL_DIS = 5;
	localparam int CTRL_RATE_LO = 6;
	localparam int CTRL_STAT_LO = 8;
	localparam logic [15:0] CTRL_RST = 16'h0060;
	localparam logic [15:0] CTRL_SW_MASK = 16'h8cef;
	localparam logic [31:0] ADDR_DATA_RST = 32'h0000_0000;

	localparam logic [2:0] CMD_WRSR = 3'h1;
	localparam logic [2:0] CMD_WRITE = 3'h2;
	localparam logic [2:0] CMD_READ = 3'h3;
	localparam logic [2:0] CMD_WRDI = 3'h4;
	localparam logic [2:0] CMD_RDSR = 3'h5;
	localparam logic [2:0] CMD_WREN = 3'h6;

	////////////////////////////////////////////////////////////////////////////
	// Serial clock: a divide by 64 of the core clock, or by 4 in test mode, half of it per level.
	localparam logic [1:0] RATE_NORM = 2'h1;
	localparam logic [1:0] RATE_TEST = 2'h3;
	localparam int SCK_DIV_NORM = 64;
	localparam int SCK_DIV_TEST = 4;
	localparam logic [5:0] HALF_NORM = 6'(SCK_DIV_NORM / 2);
	localparam logic [5:0] HALF_TEST = 6'(SCK_DIV_TEST / 2);

	////////////////////////////////////////////////////////////////////////////
	// Autoload and interrupts. The signature value is arbitrary.
	localparam logic [15:0] AUTOLOAD_ADDR = 16'h0000;
	localparam logic [15:0] AUTOLOAD_SIG = 16'h5a5a;
	localparam int IRQ_W = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_AL_OK = 1;
	localparam int IRQ_AL_FAIL = 2;
	localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

	typedef enum {SEL_NONE, SEL_CTRL, SEL_AD, SEL_IST, SEL_IMSK} sea_sel_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic has_addr;
		logic [1:0] nbytes;
		logic [15:0] addr;
		logic [15:0] wdata;
	} sea_req_t;

	typedef struct packed {
		logic sck;
		logic cs_n;
		logic mosi;
	} sea_pins_t;

endpackage

// ---- logic/sea_spi_eng.sv ----
`timescale 1ns/1ps
module sea_spi_eng
	import sea_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Request
	input wire logic start,
	input sea_req_t req,
	input wire logic tick,
	// Result
	output logic busy,
	output logic done,
	output logic [15:0] rdata,
	// Serial pins, miso already synchronised
	output sea_pins_t pins,
	input wire logic miso_s
);

	typedef enum {E_IDLE, E_SHIFT, E_END} sea_est_t;
	sea_est_t st_r, st_nxt;
	logic [39:0] tx_r, tx_nxt;
	logic [15:0] rx_r, rx_nxt, rdata_r, rdata_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic sck_r, sck_nxt, cs_n_r, cs_n_nxt, done_r, done_nxt;

	function automatic logic [5:0] frame_bits(input sea_req_t q);
		return 6'd8 + (q.has_addr ? 6'd16 : 6'd0) + {1'b0, q.nbytes, 3'b000};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Mode 0 framing: data out while the clock is low, sampled on its rise.
	always_comb begin
		st_nxt = st_r;
		tx_nxt = tx_r;
		rx_nxt = rx_r;
		cnt_nxt = cnt_r;
		sck_nxt = sck_r;
		cs_n_nxt = cs_n_r;
		rdata_nxt = rdata_r;
		done_nxt = 1'b0;
		case (st_r)
			E_IDLE: if (start) begin
				st_nxt = E_SHIFT;
				cs_n_nxt = 1'b0;
				cnt_nxt = frame_bits(req);
				if (req.has_addr)
					tx_nxt = {req.opcode, req.addr, req.wdata};
				else
					tx_nxt = {req.opcode, req.wdata[7:0], 24'h000000};
			end
			E_SHIFT: if (tick) begin
				if (!sck_r) begin
					sck_nxt = 1'b1;
					rx_nxt = {rx_r[14:0], miso_s};
				end else begin
					sck_nxt = 1'b0;
					tx_nxt = {tx_r[38:0], 1'b0};
					cnt_nxt = cnt_r - 6'd1;
					if (cnt_r == 6'd1)
						st_nxt = E_END;
				end
			end
			E_END: if (tick) begin
				cs_n_nxt = 1'b1;
				done_nxt = 1'b1;
				rdata_nxt = rx_r;
				st_nxt = E_IDLE;
			end
			default: st_nxt = E_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= E_IDLE;
			tx_r <= '0;
			rx_r <= '0;
			cnt_r <= '0;
			sck_r <= 1'b0;
			cs_n_r <= 1'b1;
			rdata_r <= '0;
			done_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			tx_r <= tx_nxt;
			rx_r <= rx_nxt;
			cnt_r <= cnt_nxt;
			sck_r <= sck_nxt;
			cs_n_r <= cs_n_nxt;
			rdata_r <= rdata_nxt;
			done_r <= done_nxt;
		end
	end

	assign busy = (st_r != E_IDLE);
	assign done = done_r;
	assign rdata = rdata_r;
	assign pins = '{sck: sck_r, cs_n: cs_n_r, mosi: tx_r[39]};

	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	cs_frame_a: assert property (st_r == E_SHIFT |-> !cs_n_r) else $error("select high in frame");
	sck_idle_a: assert property (cs_n_r |-> !sck_r) else $error("clock moves outside frame");
	done_pulse_a: assert property (done_r |=> !done_r && !busy) else $error("done not one pulse");

endmodule // sea_spi_eng

// ---- testbench/sea_eeprom_model.sv ----
`timescale 1ns/1ps
module sea_eeprom_model #(
	parameter int WIP_NS = 20000
) (
	// Serial pins
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso
);
	logic [7:0] op;
	logic [39:0] sh;
	logic [15:0] rd;
	logic wip = 1'h0;
	logic wel = 1'h0;
	logic [2:0] bp = 3'h0;
	logic [15:0] mem [logic [15:0]];
	int n;
	initial miso = 1'h0;
	////////////////////////////////////////////////////////////////////////////
	always @(negedge cs_n) n = 0;
	always @(posedge sck) begin
		if (!cs_n) begin
			sh = {sh[38:0], mosi};
			n = n + 1;
			if (n == 8) begin
				op = sh[7:0];
				rd = {bp[2], 3'h0, bp[1:0], wel, wip, 8'h00};
			end
			if (n == 24 && op == 8'h03)
				rd = mem.exists(sh[15:0]) ? mem[sh[15:0]] : 16'hffff;
			// Next bit goes out right after the rise, a full period ahead of its sample.
			if ((op == 8'h05 && n >= 8) || (op == 8'h03 && n >= 24)) begin
				miso = rd[15];
				rd = rd << 1;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// A released line shows the inverse of its last value, never a held bit.
	always @(posedge cs_n) begin
		miso = ~miso;
		if (op == 8'h06) wel = 1'h1;
		if (op == 8'h04) wel = 1'h0;
		if (wel && !wip && ((op == 8'h01 && n == 16) || (op == 8'h02 && n == 40))) begin
			if (op == 8'h01) bp = {sh[7], sh[3:2]};
			else mem[sh[31:16]] = sh[15:0];
			wip = 1'h1;
			fork
				begin
					#(WIP_NS);
					wip = 1'h0;
					wel = 1'h0;
				end
			join_none
		end
	end
endmodule // sea_eeprom_model

// ---- testbench/sea_ctrl_tb_top.sv ----
`timescale 1ns/1ps
module sea_ctrl_tb_top
	import sea_pkg::*;
;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = '0, rdata, v;
	logic awready, wready, bvalid, arready, rvalid, irq, fund_n = 1'h1;
	logic [1:0] bresp, rresp, resp;
	wire sck, cs_n, mosi, miso;
	logic [15:0] ctl, a16, d16;
	logic sck_d = 1'h0, cs_d = 1'h1;
	int fails = 0, n_compared = 0, cyc = 0, nfr = 0, per = 0, last = 0, f, k;
	sea_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .eeprom_sck(sck), .eeprom_cs_n(cs_n), .eeprom_mosi(mosi),
		.eeprom_miso(miso), .fundamental_reset_input_n(fund_n), .irq(irq));
	sea_eeprom_model m (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));
	initial forever #12.5 aclk = ~aclk;
	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Frame count and serial clock period, sampled in the core clock domain.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		sck_d <= sck;
		cs_d <= cs_n;
		if (!cs_n && cs_d) nfr <= nfr + 1;
		if (sck && !sck_d) begin
			per <= cyc - last;
			last <= cyc;
		end
		if (cyc == 60000) begin
			fails++;
			print_verdict;
		end
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [15:0] sw_exp(input logic [15:0] old, input logic [15:0] w);
		return (w & CTRL_SW_MASK) | (old & ~CTRL_SW_MASK);
	endfunction
	////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'h0;
		w_ok = 1'h0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awvalid && awready === 1'h1) begin
				aw_ok = 1'h1;
				awvalid <= 1'h0;
			end
			if (wvalid && wready === 1'h1) begin
				w_ok = 1'h1;
				wvalid <= 1'h0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'h1);
		resp = bresp;
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge aclk); while (rvalid !== 1'h1);
		d = rdata;
		resp = rresp;
		rready <= 1'h0;
	endtask
	task automatic do_cmd(input logic [2:0] c);
		int j;
		j = 0;
		wr(OFF_CTRL, {16'h0, ctl | {12'h0, c, 1'h1}});
		do begin
			rd(OFF_CTRL, v);
			j++;
		end while (v[0] && j < 2000);
		check("start clears", v[0], 1'h0);
	endtask
	task automatic wait_wip;
		int j;
		j = 0;
		do begin
			do_cmd(CMD_RDSR);
			j++;
		end while (v[8] && j < 100);
	endtask
	task automatic pulse;
		wr(OFF_IRQ_STAT, 32'h7);
		fund_n <= 1'h0;
		repeat (4) @(posedge aclk);
		fund_n <= 1'h1;
		k = 0;
		do begin
			rd(OFF_IRQ_STAT, v);
			k++;
		end while (v[2:1] == 2'h0 && k < 300);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		k = $urandom(21);
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		rd(OFF_CTRL, v);
		check("ctrl reset", v, {16'h0, CTRL_RST});
		rd(OFF_ADDR_DATA, v);
		check("addr data reset", v, ADDR_DATA_RST);
		rd(12'h0fc, v);
		check("unmapped read", {v[29:0], resp}, {30'h0, RESP_SLVERR});
		wr(12'h0fc, 32'hffff_ffff);
		check("unmapped write", {30'h0, resp}, {30'h0, RESP_SLVERR});
		wr(OFF_CTRL, 32'hffff_fff0);
		rd(OFF_CTRL, v);
		check("ctrl access", v, {16'h0, sw_exp(CTRL_RST, 16'hfff0)});
		ctl = 16'h00c0;
		wr(OFF_CTRL, {16'h0, ctl});
		for (int i = 0; i < 3; i++) begin
			wdata <= $urandom;
			wr(OFF_ADDR_DATA, wdata ^ 32'($urandom));
			d16 = wdata[31:16];
			rd(OFF_ADDR_DATA, v);
			check("addr data rw", v, wdata);
		end
		f = nfr;
		do_cmd(3'h0);
		do_cmd(3'h7);
		check("no frame", 32'(nfr), 32'(f));
		// Erased memory word 0 does not carry the signature, so autoload fails.
		pulse;
		check("autoload fail", v[2:1], 2'h2);
		for (int i = 0; i < 3; i++) begin
			// Random addresses stay odd so they never overwrite the autoload word.
			a16 = (i == 0) ? AUTOLOAD_ADDR : {15'($urandom), 1'h1};
			d16 = (i == 0) ? AUTOLOAD_SIG : 16'($urandom);
			wr(OFF_ADDR_DATA, {d16, a16});
			do_cmd(CMD_WREN);
			do_cmd(CMD_RDSR);
			check("latch set", v[9], 1'h1);
			do_cmd(CMD_WRITE);
			do_cmd(CMD_RDSR);
			check("busy set", v[8], 1'h1);
			wait_wip;
			check("busy clear", v[9:8], 2'h0);
			check("memory word", m.mem[a16], d16);
			wr(OFF_ADDR_DATA, {16'h0, a16});
			do_cmd(CMD_READ);
			rd(OFF_ADDR_DATA, v);
			check("read data", v, {d16, a16});
		end
		pulse;
		check("autoload ok", v[2:1], 2'h1);
		rd(OFF_CTRL, v);
		check("autoload bit", v[4], 1'h1);
		do_cmd(CMD_WREN);
		do_cmd(CMD_WRDI);
		do_cmd(CMD_RDSR);
		check("latch cleared", v[9], 1'h0);
		do_cmd(CMD_WREN);
		ctl = 16'h8cc0;
		do_cmd(CMD_WRSR);
		wait_wip;
		ctl = 16'h00c0;
		do_cmd(CMD_RDSR);
		check("protect bits", v[15:8], 8'h8c);
		wr(OFF_IRQ_STAT, 32'h7);
		wr(OFF_IRQ_MASK, 32'h6);
		do_cmd(CMD_RDSR);
		check("irq masked", irq, 1'h0);
		rd(OFF_IRQ_STAT, v);
		check("done status", v, 32'h1);
		wr(OFF_IRQ_MASK, 32'h1);
		check("irq raised", irq, 1'h1);
		wr(OFF_IRQ_STAT, 32'h1);
		check("irq cleared", irq, 1'h0);
		check("sck test rate", 32'(per), 32'(SCK_DIV_TEST));
		ctl = 16'h0040;
		do_cmd(CMD_RDSR);
		check("sck normal rate", 32'(per), 32'(SCK_DIV_NORM));
		ctl = 16'h00e0;
		wr(OFF_CTRL, {16'h0, ctl});
		f = nfr;
		pulse;
		rd(OFF_CTRL, v);
		check("autoload off", {v[4], 31'(nfr - f)}, 32'h0);
		print_verdict;
	end
endmodule // sea_ctrl_tb_top
